// >>> core/mssr_pkg.sv
package mssr_pkg;
    // Register map, byte offsets on the serial link
    localparam logic [7:0] MSSR_ADDR_RUN = 8'h21;
    localparam logic [7:0] MSSR_ADDR_TRIGGER = 8'h22;
    localparam logic [7:0] MSSR_ADDR_STOP = 8'h23;
    localparam logic [7:0] MSSR_ADDR_STATUS = 8'h24;
    localparam logic [7:0] MSSR_ADDR_TEMP = 8'h30;
    localparam logic [7:0] MSSR_ADDR_HUM = 8'h33;

    // Per-sensor bit positions in run, trigger, stop and status
    localparam int MSSR_BIT_TEMP = 0;
    localparam int MSSR_BIT_HUM = 1;

    // Result word field layout
    localparam int MSSR_VALUE_MSB = 15;
    localparam int MSSR_VALID_BIT = 16;
    localparam int MSSR_CRC_LSB = 17;
    localparam int MSSR_CRC_MSB = 23;

    // Reset values
    localparam logic [1:0] MSSR_RUN_RST = 2'h0;
    localparam logic [23:0] MSSR_RESULT_RST = 24'h00_0000;

    // Check code generator
    localparam logic [6:0] MSSR_CRC_POLY = 7'h09;
    localparam logic [6:0] MSSR_CRC_INIT = 7'h7f;

    // Defaults: serial slave address (arbitrary) and measurement length in clk cycles
    localparam logic [6:0] MSSR_DEV_ADDR_DEF = 7'h40;
    localparam int MSSR_MEAS_CYCLES_DEF = 1000;

    // Serial slave states, one-hot
    typedef enum logic [4:0] {
        ST_IDLE = 5'b0_0001,
        ST_RX = 5'b0_0010,
        ST_ACK = 5'b0_0100,
        ST_TX = 5'b0_1000,
        ST_RACK = 5'b1_0000
    } mssr_link_st_t;

    // What the next received byte means
    typedef enum logic [1:0] {
        K_ADDR = 2'h0,
        K_PTR = 2'h1,
        K_DATA = 2'h2
    } mssr_byte_kind_t;
endpackage : mssr_pkg

// >>> core/mssr_crc7.sv
module mssr_crc7 (
    input wire logic [16:0] data,
    output logic [6:0] crc
);
    import mssr_pkg::*;

    // Serial divider unrolled over the 17 bits, most significant first
    always_comb begin
        logic fb;
        fb = 1'b0;
        crc = MSSR_CRC_INIT;
        for (int k = 16; k >= 0; k--) begin
            fb = crc[6] ^ data[k];
            crc = {crc[5:0], 1'b0} ^ (fb ? MSSR_CRC_POLY : 7'h00);
        end
    end
endmodule : mssr_crc7

// >>> core/mssr_readout.sv
module mssr_readout #(
    parameter int MEAS_CYCLES = mssr_pkg::MSSR_MEAS_CYCLES_DEF,
    parameter logic [6:0] DEV_ADDR = mssr_pkg::MSSR_DEV_ADDR_DEF
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic [15:0] temp_sample,
    input wire logic [15:0] hum_sample
);
    import mssr_pkg::*;

    localparam int CW = $clog2(MEAS_CYCLES + 1);
    localparam logic [CW-1:0] MEAS_LOAD = CW'(MEAS_CYCLES);

    generate
        if (MEAS_CYCLES < 2) begin : g_bad_meas
            $error("MEAS_CYCLES must be at least 2");
        end
    endgenerate

    logic scl_s1, scl_s2, scl_d;
    logic sda_s1, sda_s2, sda_d;
    logic scl_rise, scl_fall, start_cond, stop_cond;
    mssr_link_st_t state_r;
    mssr_byte_kind_t kind_r;
    logic [3:0] bit_cnt_r;
    logic [7:0] shift_r;
    logic [7:0] tx_r;
    logic [7:0] ptr_r;
    logic rw_r;
    logic sda_oe_r;
    logic wr_en, ld_tx;
    logic [7:0] rd_byte;
    logic [1:0] run_r;
    logic [1:0] trig_p_r;
    logic [1:0] stop_p_r;
    logic [1:0] busy_r;
    logic [15:0] samp [2];
    logic [23:0] res [2];
    logic [23:0] shadow_r [2];

    // Two-stage synchronisers; edges are found only past the second stage
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            scl_s1 <= 1'b1;
            scl_s2 <= 1'b1;
            scl_d <= 1'b1;
            sda_s1 <= 1'b1;
            sda_s2 <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_s1 <= scl_in;
            scl_s2 <= scl_s1;
            scl_d <= scl_s2;
            sda_s1 <= sda_in;
            sda_s2 <= sda_s1;
            sda_d <= sda_s2;
        end
    end

    // Bus events; data only changes while clock low, so these are unambiguous
    assign scl_rise = scl_s2 & ~scl_d;
    assign scl_fall = ~scl_s2 & scl_d;
    assign start_cond = scl_s2 & scl_d & sda_d & ~sda_s2;
    assign stop_cond = scl_s2 & scl_d & ~sda_d & sda_s2;

    // Byte write completes on the falling edge after the eighth data bit
    assign wr_en = (state_r == ST_RX) && (kind_r == K_DATA) && scl_fall && (bit_cnt_r == 4'h8);
    // Next read byte is fetched when the ack slot ends
    assign ld_tx = scl_fall && (((state_r == ST_ACK) && rw_r) || (state_r == ST_RACK));

    // Serial slave: address, register pointer, auto-incrementing data bytes
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= ST_IDLE;
            kind_r <= K_ADDR;
            bit_cnt_r <= 4'h0;
            shift_r <= 8'h00;
            tx_r <= 8'h00;
            ptr_r <= 8'h00;
            rw_r <= 1'b0;
            sda_oe_r <= 1'b0;
        end else if (start_cond) begin
            state_r <= ST_RX;
            kind_r <= K_ADDR;
            bit_cnt_r <= 4'h0;
            sda_oe_r <= 1'b0;
        end else if (stop_cond) begin
            state_r <= ST_IDLE;
            sda_oe_r <= 1'b0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    sda_oe_r <= 1'b0;
                end
                ST_RX: begin
                    if (scl_rise) begin
                        shift_r <= {shift_r[6:0], sda_s2};
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                    end else if (scl_fall && bit_cnt_r == 4'h8) begin
                        bit_cnt_r <= 4'h0;
                        case (kind_r)
                            K_ADDR: begin
                                if (shift_r[7:1] == DEV_ADDR) begin
                                    rw_r <= shift_r[0];
                                    sda_oe_r <= 1'b1;
                                    state_r <= ST_ACK;
                                end else begin
                                    state_r <= ST_IDLE;
                                end
                            end
                            K_PTR: begin
                                ptr_r <= shift_r;
                                sda_oe_r <= 1'b1;
                                state_r <= ST_ACK;
                            end
                            default: begin
                                ptr_r <= ptr_r + 8'h01;
                                sda_oe_r <= 1'b1;
                                state_r <= ST_ACK;
                            end
                        endcase
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        if (rw_r) begin
                            sda_oe_r <= ~rd_byte[7];
                            tx_r <= {rd_byte[6:0], 1'b0};
                            bit_cnt_r <= 4'h1;
                            ptr_r <= ptr_r + 8'h01;
                            state_r <= ST_TX;
                        end else begin
                            sda_oe_r <= 1'b0;
                            kind_r <= (kind_r == K_ADDR) ? K_PTR : K_DATA;
                            state_r <= ST_RX;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        if (bit_cnt_r == 4'h8) begin
                            sda_oe_r <= 1'b0;
                            state_r <= ST_RACK;
                        end else begin
                            sda_oe_r <= ~tx_r[7];
                            tx_r <= {tx_r[6:0], 1'b0};
                            bit_cnt_r <= bit_cnt_r + 4'h1;
                        end
                    end
                end
                ST_RACK: begin
                    // Master nack ends the read; ack fetches the next byte
                    if (scl_rise && sda_s2) begin
                        state_r <= ST_IDLE;
                    end else if (scl_fall) begin
                        sda_oe_r <= ~rd_byte[7];
                        tx_r <= {rd_byte[6:0], 1'b0};
                        bit_cnt_r <= 4'h1;
                        ptr_r <= ptr_r + 8'h01;
                        state_r <= ST_TX;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                    sda_oe_r <= 1'b0;
                end
            endcase
        end
    end

    // Open-drain: only ever pull low
    assign sda_out = 1'b0;
    assign sda_oe = sda_oe_r;

    // Run mode register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            run_r <= MSSR_RUN_RST;
        end else if (wr_en && ptr_r == MSSR_ADDR_RUN) begin
            run_r <= shift_r[1:0];
        end
    end

    // Trigger and stop are write-only one-cycle pulses; zeros do nothing
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            trig_p_r <= 2'h0;
            stop_p_r <= 2'h0;
        end else begin
            trig_p_r <= (wr_en && ptr_r == MSSR_ADDR_TRIGGER) ? shift_r[1:0] : 2'h0;
            stop_p_r <= (wr_en && ptr_r == MSSR_ADDR_STOP) ? shift_r[1:0] : 2'h0;
        end
    end

    assign samp[MSSR_BIT_TEMP] = temp_sample;
    assign samp[MSSR_BIT_HUM] = hum_sample;

    // One measurement engine per sensor, index 0 temperature, 1 humidity
    for (genvar i = 0; i < 2; i++) begin : g_sens
        logic [CW-1:0] cnt_r;
        logic [15:0] val_r;
        logic vld_r;
        logic [6:0] crc_r;
        logic [6:0] crc_new;
        logic [7:0] base;

        assign base = (i == MSSR_BIT_TEMP) ? MSSR_ADDR_TEMP : MSSR_ADDR_HUM;

        // Check code over valid flag and value as they will be stored
        mssr_crc7 u_crc (
            .data({1'b1, samp[i]}),
            .crc(crc_new)
        );

        // Stop only aborts continuous runs, so a single shot still completes
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                busy_r[i] <= 1'b0;
                cnt_r <= '0;
                val_r <= 16'h0000;
                vld_r <= 1'b0;
                crc_r <= 7'h00;
            end else if (stop_p_r[i] && run_r[i]) begin
                busy_r[i] <= 1'b0;
            end else if (busy_r[i] && cnt_r == 1) begin
                val_r <= samp[i];
                vld_r <= 1'b1;
                crc_r <= crc_new;
                if (run_r[i]) begin
                    cnt_r <= MEAS_LOAD;
                end else begin
                    busy_r[i] <= 1'b0;
                end
            end else if (busy_r[i]) begin
                cnt_r <= cnt_r - 1'b1;
            end else if (trig_p_r[i]) begin
                busy_r[i] <= 1'b1;
                cnt_r <= MEAS_LOAD;
            end
        end

        assign res[i] = {crc_r, vld_r, val_r};

        // Snapshot taken as the first byte leaves, so later bytes match it
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                shadow_r[i] <= MSSR_RESULT_RST;
            end else if (ld_tx && ptr_r == base) begin
                shadow_r[i] <= res[i];
            end
        end
    end

    // Read data; first result byte is live, the others from the snapshot
    always_comb begin
        case (ptr_r)
            MSSR_ADDR_RUN: rd_byte = {6'h00, run_r};
            MSSR_ADDR_STATUS: rd_byte = {6'h00, busy_r};
            MSSR_ADDR_TEMP: rd_byte = res[MSSR_BIT_TEMP][7:0];
            MSSR_ADDR_TEMP + 8'h01: rd_byte = shadow_r[MSSR_BIT_TEMP][15:8];
            MSSR_ADDR_TEMP + 8'h02: rd_byte = shadow_r[MSSR_BIT_TEMP][23:16];
            MSSR_ADDR_HUM: rd_byte = res[MSSR_BIT_HUM][7:0];
            MSSR_ADDR_HUM + 8'h01: rd_byte = shadow_r[MSSR_BIT_HUM][15:8];
            MSSR_ADDR_HUM + 8'h02: rd_byte = shadow_r[MSSR_BIT_HUM][23:16];
            default: rd_byte = 8'h00;
        endcase
    end
endmodule : mssr_readout

// >>> tb/mssr_chk.sv
module mssr_chk (
    input wire logic clk,
    input wire logic rst,
    input wire logic scl_in,
    input wire logic sda_out,
    input wire logic sda_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic [6:0] run_r;
    // Drive length; one byte plus ack at most
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            run_r <= 7'h00;
        end else begin
            run_r <= sda_oe ? run_r + 7'h01 : 7'h00;
        end
    end
    // Open drain: never drives a one
    chk_only_pulls_low: assert property (sda_out == 1'b0)
        else $error("data line driven high");
    chk_quiet_after_rst: assert property ($fell(rst) |-> !sda_oe [*3])
        else $error("drive right after reset");
    // Idle bus is never pulled low
    chk_idle_no_drive: assert property (scl_in [*8] |-> !sda_oe)
        else $error("drive on idle bus");
    chk_still_scl_high: assert property (scl_in [*4] |-> $stable(sda_oe))
        else $error("data moved with clock high");
    // Changes land only in the clock low phase
    chk_move_scl_low: assert property ($changed(sda_oe) |-> !$past(scl_in, 1) && !$past(scl_in, 2))
        else $error("data moved off the low phase");
    chk_bit_min_len: assert property ($rose(sda_oe) |-> sda_oe [*6])
        else $error("low bit too short");
    chk_gap_min_len: assert property ($fell(sda_oe) |-> !sda_oe [*6])
        else $error("released bit too short");
    chk_drive_bounded: assert property (run_r < 7'h64)
        else $error("data line held too long");
endmodule : mssr_chk

bind mssr_readout mssr_chk u_mssr_chk (.clk(clk), .rst(rst), .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe));

// >>> tb/mssr_host.sv
module mssr_host (
    input wire logic clk,
    input wire logic sda,
    output logic scl,
    output logic sda_m
);
    timeunit 1ns;
    timeprecision 1ps;
    import mssr_pkg::*;
    logic [6:0] adr;
    logic nak;
    // Idle bus: lines released, link clock still
    initial begin
        scl = 1'b1;
        sda_m = 1'b1;
        adr = MSSR_DEV_ADDR_DEF;
        nak = 1'b0;
    end
    task automatic tk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tk
    // Start or stop: data moves while the clock is high
    task automatic cond(input logic a, input logic b);
        tk(1);
        sda_m = a;
        tk(3);
        scl = 1'b1;
        tk(4);
        sda_m = b;
        tk(4);
    endtask : cond
    // Data set one cycle after the fall, read late in the high phase
    task automatic bitx(input logic b, output logic r);
        tk(1);
        sda_m = b;
        tk(3);
        scl = 1'b1;
        tk(4);
        r = sda;
        scl = 1'b0;
    endtask : bitx
    task automatic bytex(input logic [7:0] d, input logic m, output logic [7:0] q, output logic a);
        for (int i = 7; i >= 0; i--) begin
            bitx(d[i], q[i]);
        end
        bitx(m, a);
    endtask : bytex
    // Pointer set, then one byte written (n 0) or n bytes read
    task automatic xfer(input logic [7:0] p, input logic [7:0] d, input int n, output logic [23:0] v);
        logic [7:0] q;
        logic a;
        v = 24'h00_0000;
        cond(1'b1, 1'b0);
        scl = 1'b0;
        bytex({adr, 1'b0}, 1'b1, q, a);
        nak = a;
        bytex(p, 1'b1, q, a);
        if (n == 0) begin
            bytex(d, 1'b1, q, a);
        end else begin
            cond(1'b1, 1'b0);
            scl = 1'b0;
            bytex({adr, 1'b1}, 1'b1, q, a);
            for (int i = 0; i < n; i++) begin
                bytex(8'hff, i == n - 1, q, a);
                v[8 * i +: 8] = q;
            end
        end
        cond(1'b0, 1'b1);
    endtask : xfer
endmodule : mssr_host

// >>> tb/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import mssr_pkg::*;
    localparam int MEAS = 800;
    logic clk;
    logic rst;
    logic scl;
    logic sda_m;
    logic sda_oe;
    logic [15:0] t_smp;
    logic [15:0] h_smp;
    logic [23:0] v;
    int n_fail;
    int comparisons;
    // Open-drain wire with pull-up
    wire sda = sda_m & ~sda_oe;
    mssr_readout #(.MEAS_CYCLES(MEAS)) u_mssr_readout (
        .clk(clk),
        .rst(rst),
        .scl_in(scl),
        .sda_in(sda),
        .sda_out(),
        .sda_oe(sda_oe),
        .temp_sample(t_smp),
        .hum_sample(h_smp)
    );
    mssr_host u_mssr_host (.clk(clk), .sda(sda), .scl(scl), .sda_m(sda_m));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Expected word: check code over valid flag and value
    function automatic logic [23:0] res_word(input logic [15:0] d);
        logic [16:0] x;
        logic [6:0] c;
        x = {1'b1, d};
        c = MSSR_CRC_INIT;
        for (int i = 16; i >= 0; i--) begin
            c = {c[5:0], 1'b0} ^ ((c[6] ^ x[i]) ? MSSR_CRC_POLY : 7'h00);
        end
        return {c, x};
    endfunction : res_word
    task automatic cmp(input logic [23:0] g, input logic [23:0] e);
        comparisons++;
        if (g !== e) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : cmp
    task automatic wr(input logic [7:0] p, input logic [7:0] d);
        u_mssr_host.xfer(p, d, 0, v);
    endtask : wr
    task automatic rc(input logic [7:0] p, input int n, input logic [23:0] e);
        u_mssr_host.xfer(p, 8'h00, n, v);
        cmp(v, e);
    endtask : rc
    task automatic t_reset();
        rc(MSSR_ADDR_STATUS, 1, 24'h00_0000);
        rc(MSSR_ADDR_HUM, 3, MSSR_RESULT_RST);
        $display("reset test done");
    endtask : t_reset
    // Single shot: busy, stop ignored, result still captured
    task automatic t_single();
        wr(MSSR_ADDR_TRIGGER, 8'h03);
        rc(MSSR_ADDR_STATUS, 1, 24'h00_0003);
        wr(MSSR_ADDR_STOP, 8'h03);
        u_mssr_host.tk(MEAS);
        rc(MSSR_ADDR_STATUS, 1, 24'h00_0000);
        rc(MSSR_ADDR_TEMP, 3, res_word(16'h1234));
        rc(MSSR_ADDR_HUM, 3, res_word(16'habcd));
        $display("single shot test done");
    endtask : t_single
    // Continuous: stop one sensor at a time, foreign address ignored
    task automatic t_cont();
        wr(MSSR_ADDR_RUN, 8'h03);
        wr(MSSR_ADDR_TRIGGER, 8'h03);
        t_smp = 16'h0f0f;
        u_mssr_host.tk(MEAS);
        rc(MSSR_ADDR_STATUS, 1, 24'h00_0003);
        rc(MSSR_ADDR_RUN, 1, 24'h00_0003);
        u_mssr_host.adr = MSSR_DEV_ADDR_DEF ^ 7'h01;
        wr(MSSR_ADDR_STOP, 8'h03);
        u_mssr_host.adr = MSSR_DEV_ADDR_DEF;
        cmp({23'h00_0000, u_mssr_host.nak}, 24'h00_0001);
        wr(MSSR_ADDR_STOP, 8'h01);
        rc(MSSR_ADDR_STATUS, 1, 24'h00_0002);
        t_smp = 16'h5555;
        h_smp = 16'h5555;
        u_mssr_host.tk(MEAS);
        rc(MSSR_ADDR_TEMP, 3, res_word(16'h0f0f));
        rc(MSSR_ADDR_HUM, 3, res_word(16'h5555));
        wr(MSSR_ADDR_STOP, 8'h02);
        rc(MSSR_ADDR_STATUS, 1, 24'h00_0000);
        $display("continuous test done");
    endtask : t_cont
    // Upper bytes alone give the older snapshot
    task automatic t_snap();
        t_smp = 16'h8001;
        wr(MSSR_ADDR_RUN, 8'h00);
        wr(MSSR_ADDR_TRIGGER, 8'h01);
        rc(MSSR_ADDR_STATUS, 1, 24'h00_0001);
        u_mssr_host.tk(MEAS);
        rc(MSSR_ADDR_TEMP + 8'h01, 2, res_word(16'h0f0f) >> 8);
        rc(MSSR_ADDR_TEMP, 3, res_word(16'h8001));
        rc(MSSR_ADDR_STATUS, 1, 24'h00_0000);
        $display("snapshot test done");
    endtask : t_snap
    task automatic summarize();
        $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : summarize
    // Watchdog at a few times the expected run of some 12k cycles
    initial begin
        #800_000;
        n_fail++;
        summarize();
    end
    initial begin
        n_fail = 0;
        comparisons = 0;
        rst = 1'b1;
        t_smp = 16'h1234;
        h_smp = 16'habcd;
        repeat (5) @(posedge clk);
        #1;
        rst = 1'b0;
        u_mssr_host.tk(3);
        t_reset();
        t_single();
        t_cont();
        t_snap();
        summarize();
    end
endmodule : tb_top
